// ==== hdl/dtc_pkg.sv ====
// Shared constants and types of the dual timer/counter block.
package dtc_pkg;
   // ****************************************
   // Register indices and byte addresses
   // ****************************************
   localparam int ADDR_W = 10;
   localparam logic [7:0] IDX_RUNFLAGS = 8'h88;
   localparam logic [7:0] IDX_MODE = 8'h89;
   localparam logic [7:0] IDX_T0LO = 8'h8a;
   localparam logic [7:0] IDX_T1LO = 8'h8b;
   localparam logic [7:0] IDX_T0HI = 8'h8c;
   localparam logic [7:0] IDX_T1HI = 8'h8d;
   localparam logic [7:0] IDX_AUXPRE = 8'ha1;
   localparam logic [7:0] IDX_AUXCLK = 8'ha3;
   localparam logic [ADDR_W-1:0] ADDR_RUNFLAGS = {IDX_RUNFLAGS, 2'b00};
   localparam logic [ADDR_W-1:0] ADDR_MODE = {IDX_MODE, 2'b00};
   localparam logic [ADDR_W-1:0] ADDR_T0LO = {IDX_T0LO, 2'b00};
   localparam logic [ADDR_W-1:0] ADDR_T1LO = {IDX_T1LO, 2'b00};
   localparam logic [ADDR_W-1:0] ADDR_T0HI = {IDX_T0HI, 2'b00};
   localparam logic [ADDR_W-1:0] ADDR_T1HI = {IDX_T1HI, 2'b00};
   localparam logic [ADDR_W-1:0] ADDR_AUXPRE = {IDX_AUXPRE, 2'b00};
   localparam logic [ADDR_W-1:0] ADDR_AUXCLK = {IDX_AUXCLK, 2'b00};

   // ****************************************
   // Field positions and reset values
   // ****************************************
   localparam int FLAG1_BIT = 7;
   localparam int RUN1_BIT = 6;
   localparam int FLAG0_BIT = 5;
   localparam int RUN0_BIT = 4;
   localparam int FAST1_BIT = 3;
   localparam int FAST0_BIT = 2;
   localparam int CKO1_BIT = 1;
   localparam int CKO0_BIT = 0;
   localparam int SLOWP_BIT = 4;
   localparam logic [7:0] RST_REG = 8'h00;
   localparam logic [7:0] BYTE_ONES = 8'hff;

   // ****************************************
   // Prescaler ratios in core clock cycles
   // ****************************************
   localparam int DIV_STD = 12;
   localparam int DIV_48 = 48;
   localparam int DIV_192 = 192;

   // ****************************************
   // Types
   // ****************************************
   typedef enum logic [1:0] {MODE_PWM8, MODE_CNT16, MODE_RELOAD8, MODE_SPLIT} dtc_mode_t;
   typedef struct packed {
      logic gate;
      logic ct;
      dtc_mode_t mode;
   } dtc_tmode_t;
endpackage : dtc_pkg

// ==== hdl/dtc_tick_div.sv ====
// Free-running divider that yields a one-cycle enable every DIV clocks.
`timescale 1ns/100ps
module dtc_tick_div
   import dtc_pkg::*;
#(
   parameter int unsigned DIV = 12
)
(
   input wire logic pclk,
   input wire logic presetn,
   output logic tick
);
   localparam int W = $clog2(DIV);
   localparam logic [W-1:0] LAST = W'(DIV - 1);

   logic [W-1:0] cnt_q;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         cnt_q <= '0;
      else if (cnt_q == LAST)
         cnt_q <= '0;
      else
         cnt_q <= cnt_q + 1'b1;
   end

   assign tick = (cnt_q == LAST);

   property p_tick_single;
      @(posedge pclk) disable iff (!presetn) tick |=> !tick;
   endproperty
   a_tick_single: assert property (p_tick_single) else $error("divider tick lasted two cycles");
endmodule : dtc_tick_div

// ==== hdl/dtc_timer_top.sv ====
// Two timer/counters with prescaler, gating, event counting and clock-out, on APB.
//
// Contract
// - Standard timer rate is one step per 12 clocks.
// - Fast-clock bit makes timer step every clock; timer 0 steps once per 192 clocks when its slow prescale bit is also set.
// - Timer 0 prescale pair picks /12, /1, /48, /192.
// - Counter samples pin per rate tick, counts falls.
// - Counted value appears one sampling cycle after detection.
// - Advance only when run set and gate satisfied; split high byte needs only timer 1's run bit.
// - Mode 0 is 8-bit, rollover sets flag.
// - Mode 1 is 16-bit from both bytes.
// - Mode 2 reloads low byte from high byte.
// - Timer 1 mode 3 holds its count.
// - Timer 0 mode 3 splits; high byte uses timer-1 controls.
// - Clock-out enable forces 8-bit reload, drives clock pin.
// - Timer 1 clock-out uses /12 or /1 only.
// - Timer 0 clock-out divides by 24, 2, 96, 384.
// - Clock-out overflow sets flag, raises no interrupt.
// - Timer 1 overflow feeds baud and clock-out alike.
// - Flags set by overflow/software, cleared by vectoring/software.
// - Run bit written one starts, zero stops.
// - Counter select chooses internal rate or external pin.
// - Mode register: timer 1 high nibble, timer 0 low.
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/100ps
module dtc_timer_top
   import dtc_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic timer0_count_input,
   input wire logic timer1_count_input,
   input wire logic external_interrupt_pin0,
   input wire logic external_interrupt_pin1,
   input wire logic timer0_vector_ack,
   input wire logic timer1_vector_ack,
   output logic timer0_irq,
   output logic timer1_irq,
   output logic timer1_overflow,
   output logic timer0_clkout_pin,
   output logic timer0_clkout_oe,
   output logic timer1_clkout_pin,
   output logic timer1_clkout_oe
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   // ****************************************
   // Register storage
   // ****************************************
   logic [1:0][7:0] tl_q;
   logic [1:0][7:0] th_q;
   logic [1:0][7:0] tl_d;
   logic [1:0][7:0] th_d;
   logic [1:0] run_q;
   logic [1:0] flag_q;
   logic [3:0] timer_run_and_flags_ext_q;
   dtc_tmode_t [1:0] timer_mode_control_q;
   logic [7:0] aux2_q;
   logic slowp_q;
   logic [31:0] prdata_q;
   logic slverr_q;
   logic [1:0] samp_q;
   logic [1:0] pend_q;
   logic [1:0] clkout_q;
   logic t1_ovf_q;

   // ****************************************
   // APB decode
   // ****************************************
   logic acc;
   logic wr;
   logic [7:0] wbyte;
   logic [7:0] rd_d;
   logic miss_d;

   assign acc = psel & penable;
   assign wr = acc & pwrite;
   assign wbyte = pwdata[7:0];
   // Zero wait states: data for a read is caught in the setup cycle.
   assign pready = 1'b1;
   assign prdata = prdata_q;
   assign pslverr = slverr_q;

   always_comb
   begin
      rd_d = 8'h00;
      miss_d = 1'b0;
      unique case (paddr)
         ADDR_RUNFLAGS: rd_d = {flag_q[1], run_q[1], flag_q[0], run_q[0], timer_run_and_flags_ext_q};
         ADDR_MODE: rd_d = timer_mode_control_q;
         ADDR_T0LO: rd_d = tl_q[0];
         ADDR_T1LO: rd_d = tl_q[1];
         ADDR_T0HI: rd_d = th_q[0];
         ADDR_T1HI: rd_d = th_q[1];
         ADDR_AUXPRE: rd_d = 8'(slowp_q) << SLOWP_BIT;
         ADDR_AUXCLK: rd_d = aux2_q;
         default: miss_d = 1'b1;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata_q <= '0;
         slverr_q <= 1'b0;
      end
      else if (psel && !penable)
      begin
         prdata_q <= {24'h000000, rd_d};
         slverr_q <= miss_d;
      end
   end

   logic wr_timer_run_and_flags;
   logic wr_timer_mode_control;
   logic wr_aux2;
   logic wr_auxpre;
   logic [1:0] wr_tl;
   logic [1:0] wr_th;

   assign wr_timer_run_and_flags = wr && (paddr == ADDR_RUNFLAGS);
   assign wr_timer_mode_control = wr && (paddr == ADDR_MODE);
   assign wr_aux2 = wr && (paddr == ADDR_AUXCLK);
   assign wr_auxpre = wr && (paddr == ADDR_AUXPRE);
   assign wr_tl = {wr && (paddr == ADDR_T1LO), wr && (paddr == ADDR_T0LO)};
   assign wr_th = {wr && (paddr == ADDR_T1HI), wr && (paddr == ADDR_T0HI)};

   // ****************************************
   // Configuration registers
   // ****************************************
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         run_q <= 2'b00;
         timer_run_and_flags_ext_q <= 4'h0;
         timer_mode_control_q <= RST_REG;
         aux2_q <= RST_REG;
         slowp_q <= 1'b0;
      end
      else
      begin
         if (wr_timer_run_and_flags)
         begin
            run_q <= {wbyte[RUN1_BIT], wbyte[RUN0_BIT]};
            timer_run_and_flags_ext_q <= wbyte[3:0];
         end
         if (wr_timer_mode_control)
            timer_mode_control_q <= wbyte;
         if (wr_aux2)
            aux2_q <= wbyte;
         if (wr_auxpre)
            slowp_q <= wbyte[SLOWP_BIT];
      end
   end

   // ****************************************
   // Prescaler
   // ****************************************
   logic tick12;
   logic tick48;
   logic tick192;
   logic [1:0] tick;

   dtc_tick_div #(.DIV(DIV_STD)) u_div12 (.pclk(pclk), .presetn(presetn), .tick(tick12));
   dtc_tick_div #(.DIV(DIV_48)) u_div48 (.pclk(pclk), .presetn(presetn), .tick(tick48));
   dtc_tick_div #(.DIV(DIV_192)) u_div192 (.pclk(pclk), .presetn(presetn), .tick(tick192));

   always_comb
   begin
      unique case ({slowp_q, aux2_q[FAST0_BIT]})
         2'b00: tick[0] = tick12;
         2'b01: tick[0] = 1'b1;
         2'b10: tick[0] = tick48;
         2'b11: tick[0] = tick192;
      endcase
      // Timer 1 has no slow prescale, so clock-out on it is /12 or /1 only.
      tick[1] = aux2_q[FAST1_BIT] ? 1'b1 : tick12;
   end

   // ****************************************
   // Count pin sampling
   // ****************************************
   logic [1:0] pin;

   assign pin = {timer1_count_input, timer0_count_input};

   // The pin is only looked at on rate ticks, so a pulse shorter than one
   // rate cycle may be missed.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         samp_q <= 2'b00;
         pend_q <= 2'b00;
      end
      else
      begin
         for (int i = 0; i < 2; i++)
         begin
            if (tick[i])
            begin
               samp_q[i] <= pin[i];
               pend_q[i] <= samp_q[i] & ~pin[i];
            end
         end
      end
   end

   // ****************************************
   // Count engine
   // ****************************************
   logic [1:0] gate_pin;
   logic [1:0] run_ok;
   logic [1:0] cko;
   logic [1:0] ev;
   logic [1:0] ovf;
   logic split0;
   logic ev_h;
   logic ovf_h;
   dtc_mode_t [1:0] mode_eff;

   assign gate_pin = {external_interrupt_pin1, external_interrupt_pin0};
   assign split0 = (timer_mode_control_q[0].mode == MODE_SPLIT) && !cko[0];

   always_comb
   begin
      for (int i = 0; i < 2; i++)
      begin
         run_ok[i] = run_q[i] & (~timer_mode_control_q[i].gate | gate_pin[i]);
         cko[i] = aux2_q[CKO0_BIT + i] & ~timer_mode_control_q[i].ct;
         ev[i] = tick[i] & run_ok[i] & (timer_mode_control_q[i].ct ? pend_q[i] : 1'b1);
         mode_eff[i] = cko[i] ? MODE_RELOAD8 : timer_mode_control_q[i].mode;
      end
   end

   always_comb
   begin
      tl_d = tl_q;
      th_d = th_q;
      ovf = 2'b00;
      for (int i = 0; i < 2; i++)
      begin
         if (ev[i])
         begin
            unique case (mode_eff[i])
               MODE_PWM8:
               begin
                  tl_d[i] = tl_q[i] + 8'h01;
                  ovf[i] = (tl_q[i] == BYTE_ONES);
               end
               MODE_CNT16:
               begin
                  {th_d[i], tl_d[i]} = {th_q[i], tl_q[i]} + 16'h0001;
                  ovf[i] = ({th_q[i], tl_q[i]} == {BYTE_ONES, BYTE_ONES});
               end
               MODE_RELOAD8:
               begin
                  ovf[i] = (tl_q[i] == BYTE_ONES);
                  tl_d[i] = ovf[i] ? th_q[i] : tl_q[i] + 8'h01;
               end
               MODE_SPLIT:
               begin
                  if (i == 0)
                  begin
                     tl_d[i] = tl_q[i] + 8'h01;
                     ovf[i] = (tl_q[i] == BYTE_ONES);
                  end
               end
            endcase
         end
      end
      // The split high byte is a plain timer on timer 0's rate, run by timer 1's bit.
      ev_h = split0 & tick[0] & run_q[1];
      ovf_h = ev_h && (th_q[0] == BYTE_ONES);
      if (ev_h)
         th_d[0] = th_q[0] + 8'h01;
   end

   // Software writes to a count byte win over a step in the same cycle.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         tl_q <= '0;
         th_q <= '0;
      end
      else
      begin
         for (int i = 0; i < 2; i++)
         begin
            tl_q[i] <= wr_tl[i] ? wbyte : tl_d[i];
            th_q[i] <= wr_th[i] ? wbyte : th_d[i];
         end
      end
   end

   // ****************************************
   // Flags, clock-out and overflow outputs
   // ****************************************
   logic [1:0] hw_set;
   logic [1:0] ack;
   logic [1:0] wflag;

   // In split mode timer 1 loses its flag to the high byte of timer 0.
   assign hw_set = {(ovf[1] & ~split0) | ovf_h, ovf[0]};
   assign ack = {timer1_vector_ack, timer0_vector_ack};
   assign wflag = {wbyte[FLAG1_BIT], wbyte[FLAG0_BIT]};

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         flag_q <= 2'b00;
         clkout_q <= 2'b00;
         t1_ovf_q <= 1'b0;
      end
      else
      begin
         for (int i = 0; i < 2; i++)
         begin
            // A hardware set wins over any clear arriving in the same cycle.
            if (hw_set[i])
               flag_q[i] <= 1'b1;
            else if (wr_timer_run_and_flags)
               flag_q[i] <= wflag[i];
            else if (ack[i])
               flag_q[i] <= 1'b0;
            clkout_q[i] <= cko[i] ? (clkout_q[i] ^ ovf[i]) : 1'b0;
         end
         t1_ovf_q <= ovf[1];
      end
   end

   assign timer0_irq = flag_q[0] & ~cko[0];
   assign timer1_irq = flag_q[1] & ~cko[1];
   assign timer1_overflow = t1_ovf_q;
   assign timer0_clkout_pin = clkout_q[0];
   assign timer1_clkout_pin = clkout_q[1];
   assign timer0_clkout_oe = cko[0];
   assign timer1_clkout_oe = cko[1];

   // ****************************************
   // Assertions
   // ****************************************
   property p_std_rate;
      tick12 |-> ##12 tick12;
   endproperty
   a_std_rate: assert property (p_std_rate) else $error("standard rate tick not every 12");

   property p_slow_rate;
      tick192 |-> ##192 tick192;
   endproperty
   a_slow_rate: assert property (p_slow_rate) else $error("slowest tick not every 192");

   property p_fast_inc;
      (aux2_q[FAST0_BIT] && !slowp_q && !timer_mode_control_q[0].ct && run_ok[0]
         && (timer_mode_control_q[0].mode == MODE_PWM8 || timer_mode_control_q[0].mode == MODE_CNT16)
         && !cko[0] && !wr && tl_q[0] != BYTE_ONES)
         |=> tl_q[0] == $past(tl_q[0]) + 8'h01;
   endproperty
   a_fast_inc: assert property (p_fast_inc) else $error("fast timer did not step");

   property p_stop_hold;
      (!run_q[0] && !split0 && !wr) |=> $stable(tl_q[0]) && $stable(th_q[0]);
   endproperty
   a_stop_hold: assert property (p_stop_hold) else $error("stopped timer 0 moved");

   property p_reload;
      (ev[0] && mode_eff[0] == MODE_RELOAD8 && tl_q[0] == BYTE_ONES && !wr)
         |=> tl_q[0] == $past(th_q[0]) && flag_q[0] && $stable(th_q[0]);
   endproperty
   a_reload: assert property (p_reload) else $error("reload overflow wrong");

   property p_t1_hold;
      (timer_mode_control_q[1].mode == MODE_SPLIT && !cko[1] && !wr) |=> $stable(tl_q[1]) && $stable(th_q[1]);
   endproperty
   a_t1_hold: assert property (p_t1_hold) else $error("timer 1 moved in mode 3");

   property p_split_flag;
      ovf_h |=> flag_q[1];
   endproperty
   a_split_flag: assert property (p_split_flag) else $error("split high byte did not set flag 1");

   property p_toggle;
      (cko[0] && ovf[0]) |=> timer0_clkout_pin != $past(timer0_clkout_pin);
   endproperty
   a_toggle: assert property (p_toggle) else $error("clock pin did not toggle");

   property p_no_irq;
      cko[0] |-> !timer0_irq;
   endproperty
   a_no_irq: assert property (p_no_irq) else $error("interrupt in clock-out mode");

   property p_set_wins;
      (ovf[0] && (timer0_vector_ack || wr_timer_run_and_flags)) |=> flag_q[0];
   endproperty
   a_set_wins: assert property (p_set_wins) else $error("overflow lost against clear");

   property p_count_delay;
      (timer_mode_control_q[0].ct && tick[0] && samp_q[0] && !timer0_count_input)
         |=> pend_q[0];
   endproperty
   a_count_delay: assert property (p_count_delay) else $error("fall not latched");

   c_reload: cover property (ev[0] && mode_eff[0] == MODE_RELOAD8 && ovf[0]);
   c_clkout: cover property (cko[1] && ovf[1]);
   c_count: cover property (timer_mode_control_q[0].ct && ev[0]);
   c_split: cover property (ovf_h);
endmodule : dtc_timer_top

// ==== tb/dtc_pin_model.sv ====
// Partner model of the external count and gate pins.
`timescale 1ns/100ps
module dtc_pin_model
(
   input wire logic pclk,
   output logic cnt0,
   output logic cnt1,
   output logic gate0,
   output logic gate1
);
   initial
   begin
      cnt0 = 1'b1;
      cnt1 = 1'b1;
      gate0 = 1'b0;
      gate1 = 1'b0;
   end

   // Each level lasts w cycles; w below one rate cycle would lose edges.
   task automatic pulses(input int n, input int w);
      for (int i = 0; i < n; i++)
      begin
         repeat (w) @(posedge pclk);
         cnt0 <= 1'b0;
         repeat (w) @(posedge pclk);
         cnt0 <= 1'b1;
      end
   endtask : pulses

   task automatic gate(input logic g);
      @(posedge pclk);
      gate0 <= g;
      gate1 <= g;
   endtask : gate
endmodule : dtc_pin_model

// ==== tb/dual_timer_counter_clockout_tb.sv ====
// Self-checking bench of the dual timer/counter block.
`timescale 1ns/100ps
module dual_timer_counter_clockout_tb
   import dtc_pkg::*;
;
   logic pclk, presetn, psel, penable, pwrite, t0_ack, t1_ack;
   logic [ADDR_W-1:0] paddr;
   logic [31:0] pwdata, prdata;
   logic pready, pslverr, irq0, irq1, ovp, cko0, oe0, cko1, oe1;
   logic cnt0, cnt1, gate0, gate1;
   logic p0 = 1'b0;
   logic p1 = 1'b0;
   logic [32:0] exq[$];
   logic [1:0] s;
   logic [7:0] d;
   int num_errors = 0;
   int n_checks = 0;
   int tg0 = 0, tg1 = 0, ov1 = 0, a0, a1, v1, n;
   int divs[4] = '{DIV_STD, 1, DIV_48, DIV_192};
   logic [ADDR_W-1:0] regs[8] = '{ADDR_MODE, ADDR_T0LO, ADDR_T1LO, ADDR_T0HI, ADDR_T1HI,
      ADDR_AUXCLK, ADDR_RUNFLAGS, ADDR_AUXPRE};

   dtc_timer_top dut_u
   (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .timer0_count_input(cnt0), .timer1_count_input(cnt1),
      .external_interrupt_pin0(gate0), .external_interrupt_pin1(gate1),
      .timer0_vector_ack(t0_ack), .timer1_vector_ack(t1_ack),
      .timer0_irq(irq0), .timer1_irq(irq1), .timer1_overflow(ovp),
      .timer0_clkout_pin(cko0), .timer0_clkout_oe(oe0),
      .timer1_clkout_pin(cko1), .timer1_clkout_oe(oe1)
   );

   dtc_pin_model pm_u
   (
      .pclk(pclk), .cnt0(cnt0), .cnt1(cnt1), .gate0(gate0), .gate1(gate1)
   );

   always #5 pclk = ~pclk;

   // ****************************************
   // Checking and closing
   // ****************************************
   task automatic check(input string nm, input logic [32:0] seen, input logic [32:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check

   task automatic complete_run();
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : complete_run

   // ****************************************
   // APB master, entered just after a rising edge
   // ****************************************
   task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [7:0] v);
      int k;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h000000, v};
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do
      begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      psel <= 1'b0;
      penable <= 1'b0;
      if (k >= 50)
      begin
         num_errors++;
         complete_run();
      end
      // An idle cycle after each transfer keeps psel from falling and rising in one step.
      @(posedge pclk);
   endtask : apb

   task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] v);
      apb(1'b1, a, v);
   endtask : wr

   // Expected value is {slave error, byte}; upper data bits must read zero.
   task automatic rd(input logic [ADDR_W-1:0] a, input logic [8:0] e);
      exq.push_back({e[8], 24'h000000, e[7:0]});
      apb(1'b0, a, 8'h00);
   endtask : rd

   // ****************************************
   // Monitors
   // ****************************************
   always @(posedge pclk)
   begin
      if (psel && penable && pready && !pwrite && exq.size() > 0)
         check("read data", {pslverr, prdata}, exq.pop_front());
   end

   // Pins are counted on the falling edge, where they have settled.
   always @(negedge pclk)
   begin
      tg0 += int'(cko0 !== p0);
      tg1 += int'(cko1 !== p1);
      ov1 += int'(ovp === 1'b1);
      p0 = cko0;
      p1 = cko1;
   end

   initial
   begin
      #1000000;
      num_errors++;
      complete_run();
   end

   // ****************************************
   // Main sequence
   // ****************************************
   initial
   begin
      pclk = 1'b0;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
      t0_ack = 1'b0;
      t1_ack = 1'b0;
      n = $urandom(65);
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      foreach (regs[i])
         rd(regs[i], 9'h000);
      rd(10'h3fc, 9'h100);
      for (int i = 0; i < 7; i++)
      begin
         d = 8'($urandom);
         wr(regs[i], d);
         rd(regs[i], {1'b0, d});
         wr(regs[i], 8'h00);
      end
      // The idle cycle that ends each write is one of the counted rate cycles.
      foreach (divs[i])
      begin
         s = i[1:0];
         wr(ADDR_AUXPRE, {3'b000, s[1], 4'h0});
         wr(ADDR_AUXCLK, {5'h00, s[0], 2'b00});
         wr(ADDR_MODE, 8'h01);
         wr(ADDR_T0LO, 8'h00);
         wr(ADDR_RUNFLAGS, 8'h10);
         repeat (3 * divs[i] - 1) @(posedge pclk);
         rd(ADDR_T0LO, 9'h003);
         wr(ADDR_RUNFLAGS, 8'h00);
      end
      wr(ADDR_T0LO, 8'h5a);
      wr(ADDR_MODE, 8'h30);
      wr(ADDR_T1LO, 8'h33);
      wr(ADDR_RUNFLAGS, 8'h40);
      repeat (30) @(posedge pclk);
      rd(ADDR_T1LO, 9'h033);
      rd(ADDR_T0LO, 9'h05a);
      wr(ADDR_RUNFLAGS, 8'h00);
      wr(ADDR_AUXPRE, 8'h00);
      wr(ADDR_AUXCLK, 8'h04);
      wr(ADDR_MODE, 8'h09);
      wr(ADDR_T0LO, 8'h00);
      wr(ADDR_RUNFLAGS, 8'h10);
      repeat (20) @(posedge pclk);
      rd(ADDR_T0LO, 9'h000);
      wr(ADDR_RUNFLAGS, 8'h00);
      pm_u.gate(1'b1);
      wr(ADDR_RUNFLAGS, 8'h10);
      repeat (3) @(posedge pclk);
      rd(ADDR_T0LO, 9'h004);
      wr(ADDR_MODE, 8'h05);
      wr(ADDR_T0LO, 8'h00);
      n = 1 + ($urandom % 8);
      pm_u.pulses(n, 3);
      repeat (4) @(posedge pclk);
      rd(ADDR_T0LO, {1'b0, 8'(n)});
      wr(ADDR_RUNFLAGS, 8'h00);
      wr(ADDR_MODE, 8'h20);
      wr(ADDR_AUXCLK, 8'h08);
      wr(ADDR_T1HI, 8'hfe);
      wr(ADDR_T1LO, 8'hfe);
      v1 = ov1;
      wr(ADDR_RUNFLAGS, 8'h40);
      repeat (2) @(posedge pclk);
      rd(ADDR_T1LO, 9'h0ff);
      rd(ADDR_T1HI, 9'h0fe);
      // Timer 1 is stopped here, or its next overflow would undo the acknowledge.
      wr(ADDR_RUNFLAGS, 8'h80);
      rd(ADDR_RUNFLAGS, 9'h080);
      @(negedge pclk);
      check("timer 1 irq", 33'(irq1), 33'h1);
      check("baud pulses", 33'(ov1 > v1), 33'h1);
      @(posedge pclk);
      t1_ack <= 1'b1;
      @(posedge pclk);
      t1_ack <= 1'b0;
      @(negedge pclk);
      check("timer 1 irq", 33'(irq1), 33'h0);
      @(posedge pclk);
      rd(ADDR_RUNFLAGS, 9'h000);
      wr(ADDR_AUXCLK, 8'h04);
      wr(ADDR_MODE, 8'h03);
      wr(ADDR_T0LO, 8'h00);
      wr(ADDR_T0HI, 8'hfe);
      wr(ADDR_RUNFLAGS, 8'h40);
      repeat (4) @(posedge pclk);
      rd(ADDR_RUNFLAGS, 9'h0c0);
      rd(ADDR_T0LO, 9'h000);
      wr(ADDR_RUNFLAGS, 8'h00);
      foreach (divs[i])
      begin
         s = i[1:0];
         wr(ADDR_AUXPRE, {3'b000, s[1], 4'h0});
         wr(ADDR_AUXCLK, {5'h00, s[0], 2'b11});
         wr(ADDR_MODE, 8'h00);
         wr(ADDR_T0HI, 8'hfc);
         wr(ADDR_T0LO, 8'hfc);
         wr(ADDR_T1HI, 8'hfc);
         wr(ADDR_T1LO, 8'hfc);
         wr(ADDR_RUNFLAGS, 8'h50);
         // Acknowledges meet overflows while settling; the hardware set must win.
         t0_ack <= 1'b1;
         repeat (8 * divs[i]) @(posedge pclk);
         t0_ack <= 1'b0;
         a0 = tg0;
         a1 = tg1;
         v1 = ov1;
         repeat (40 * divs[i]) @(posedge pclk);
         check("clock out 0 toggles", 33'(tg0 - a0), 33'd10);
         if (s[0] == 1'b0)
         begin
            check("clock out 1 toggles", 33'(tg1 - a1), 33'(40 * divs[i] / 48));
            check("baud pulses", 33'(ov1 - v1), 33'(40 * divs[i] / 48));
         end
      end
      rd(ADDR_RUNFLAGS, 9'h0f0);
      @(negedge pclk);
      check("clock out irqs", {31'h0, irq1, irq0}, 33'h0);
      check("clock out enables", {31'h0, oe1, oe0}, 33'h3);
      @(posedge pclk);
      complete_run();
   end
endmodule : dual_timer_counter_clockout_tb
